// >>> nibble_cpu_consts.vh
`ifndef NIBBLE_CPU_CONSTS_VH
`define NIBBLE_CPU_CONSTS_VH

// Register word offsets on the bus (address bits 7:2)
`define REG_CTRL      6'h00
`define REG_STATUS    6'h01
`define REG_ETP       6'h02
`define REG_ROM_ADDR  6'h03
`define REG_ROM_DATA  6'h04
`define REG_RAM_ADDR  6'h05
`define REG_RAM_DATA  6'h06

// Control register fields
`define CTRL_RUN      0
`define CTRL_URS      1
`define CTRL_LO_LO    2
`define CTRL_LO_HI    3

// Reset values
`define RST_PAGE      4'h0
`define RST_PCL       7'h00
`define RST_LO        2'h0

// Gate function select codes
`define LO_XOR        2'h0
`define LO_OR         2'h1
`define LO_AND        2'h2

// Execution phases; table lookup runs fetch, read, return
`define CYC_FETCH     2'h0
`define CYC_WORD2     2'h1
`define CYC_TAB1      2'h2
`define CYC_TAB2      2'h3

// Instruction encodings
`define OP_B          9'b11_???????
`define OP_DEY        9'h017
`define OP_INY        9'h013
`define OP_TAM        9'b0_0110_01??
`define OP_XAM        9'b0_0110_00??
`define OP_SWAP_ACC_MEMORY_UP       9'b0_0110_10??
`define OP_SWAP_ACC_MEMORY_DOWN       9'b0_0110_11??
`define OP_LXY        9'b0_11??_????
`define OP_LA         9'b0_1011_????
`define OP_ROM_TABLE_LOOKUP       9'b0_1001_????
`define OP_TABLE_HIGH_BIT_ENABLE_SET       9'h082
`define OP_AM         9'h00a
`define OP_AMC        9'h00b
`define OP_AI         9'b0_1010_????
`define OP_SC         9'h007
`define OP_RC         9'h006
`define OP_SZC        9'h02f
`define OP_CMA        9'h01c
`define OP_RAR        9'h01d
`define OP_GATE_FUNCTION_EXECUTE       9'h041
`define OP_SB         9'b0_0101_11??
`define OP_RB         9'b0_0100_11??
`define OP_SZB        9'b0_0010_00??
`define OP_SKIP_EQUAL_MEMORY       9'h026
`define OP_SEA        9'h025
`define OP_BL         9'b0_0011_????
`define OP_BA         9'h001
`define OP_BLA        9'h010

`endif

// >>> nibble_cpu_execute_core.v
// Implementation choices: register access over AHB-Lite and the register addresses.
`include "nibble_cpu_consts.vh"

module nibble_cpu_execute_core #(
    parameter STACK_DEPTH = 4
) (
    input  wire        I_CLK,
    input  wire        I_RESET,
    input  wire        I_CE,
    input  wire        I_HSEL,
    input  wire [31:0] I_HADDR,
    input  wire [1:0]  I_HTRANS,
    input  wire        I_HWRITE,
    input  wire [2:0]  I_HSIZE,
    input  wire [31:0] I_HWDATA,
    input  wire        I_HREADY,
    output reg  [31:0] O_HRDATA,
    output reg         O_HREADYOUT,
    output reg         O_HRESP
);

    // Program ROM, data RAM and return stack
    reg  [8:0]  rom [0:2047];
    reg  [3:0]  ram [0:63];
    reg  [10:0] stack [0:STACK_DEPTH-1];

    reg  [3:0]  a_q;
    reg  [3:0]  b_q;
    reg  [1:0]  x_q;
    reg  [3:0]  y_q;
    reg         cy_q;
    reg  [7:0]  e_q;
    reg  [2:0]  dr_q;
    reg  [1:0]  lo_q;
    reg         urs_q;
    reg  [3:0]  page_q;
    reg  [6:0]  pcl_q;
    reg  [1:0]  sp_q;
    reg  [1:0]  cyc_q;
    reg  [8:0]  op_q;
    reg  [10:0] tab_q;
    reg         skip_q;
    reg         two_skip_q;
    reg         prev_lxy_q;
    reg         prev_la_q;
    reg         run_q;
    reg  [10:0] rom_addr_q;
    reg  [5:0]  ram_addr_q;
    reg  [5:0]  bus_addr_q;
    reg         rd_pend_q;
    reg         wr_pend_q;
    reg  [3:0]  gate_d;
    reg         cpu_we_d;
    reg  [3:0]  cpu_wd_d;
    reg  [31:0] rd_mux_d;

    // Fetch and operand paths
    wire [8:0]  word    = rom[{page_q, pcl_q}];
    wire [5:0]  dp      = {x_q, y_q};
    wire [3:0]  mem     = ram[dp];
    wire [8:0]  tab_wd  = rom[tab_q];
    wire [6:0]  pcl_inc = pcl_q + 7'h01;
    wire [3:0]  y_inc   = y_q + 4'h1;
    wire [3:0]  y_dec   = y_q - 4'h1;
    wire [4:0]  sum_am  = {1'b0, a_q} + {1'b0, mem};
    wire [4:0]  sum_amc = sum_am + {4'h0, cy_q};
    wire [4:0]  sum_ai  = {1'b0, a_q} + {1'b0, word[3:0]};
    wire [3:0]  bit_msk = 4'h1 << word[1:0];
    wire [6:0]  idx_pcl = {word[6:4], a_q};
    wire [1:0]  sp_dec  = sp_q - 2'h1;

    // Instruction classes
    wire is_lxy  = (word[8:6] == 3'b011);
    wire is_la   = (word[8:4] == 5'h0b);
    wire is_rom_table_lookup = (word[8:4] == 5'h09);
    wire is_two  = (word[8:4] == 5'h03) || (word == `OP_BA) ||
                   (word == `OP_BLA) || (word == `OP_SEA);
    wire run_skip = skip_q | (is_lxy & prev_lxy_q)
                           | (is_la & prev_la_q);
    wire exec    = run_q & (cyc_q == `CYC_FETCH) & ~run_skip;

    // Bus side strobes and the core's stack push
    wire bus_take   = I_HSEL & I_HREADY & I_HTRANS[1];
    wire bus_rom_we = wr_pend_q & (bus_addr_q == `REG_ROM_DATA);
    wire bus_ram_we = wr_pend_q & (bus_addr_q == `REG_RAM_DATA);
    wire stack_push = exec & is_rom_table_lookup;

    // Selected logic operation between A and E
    always @*
    begin
        case (lo_q)
            `LO_XOR: gate_d = a_q ^ e_q[3:0];
            `LO_OR:  gate_d = a_q | e_q[3:0];
            default: gate_d = a_q & e_q[3:0];
        endcase
    end

    // Memory writes by the running core
    always @*
    begin
        cpu_we_d = 1'b0;
        cpu_wd_d = mem;
        if (exec)
        begin
            casez (word)
                `OP_XAM, `OP_SWAP_ACC_MEMORY_UP, `OP_SWAP_ACC_MEMORY_DOWN:
                begin
                    cpu_we_d = 1'b1;
                    cpu_wd_d = a_q;
                end
                `OP_SB:
                begin
                    cpu_we_d = 1'b1;
                    cpu_wd_d = mem | bit_msk;
                end
                `OP_RB:
                begin
                    cpu_we_d = 1'b1;
                    cpu_wd_d = mem & ~bit_msk;
                end
                default: cpu_we_d = 1'b0;
            endcase
        end
    end

    // Arrays; the bus wins over the core on the RAM port
    always @(posedge I_CLK)
    begin
        if (I_CE)
        begin
            if (bus_rom_we)
                rom[rom_addr_q] <= I_HWDATA[8:0];
            if (bus_ram_we)
                ram[ram_addr_q] <= I_HWDATA[3:0];
            else if (cpu_we_d)
                ram[dp] <= cpu_wd_d;
            if (stack_push)
                stack[sp_q] <= {page_q, pcl_inc};
        end
    end

    // Register read multiplexer
    always @*
    begin
        case (bus_addr_q)
            `REG_CTRL:     rd_mux_d = {28'h0000000, lo_q, urs_q, run_q};
            `REG_STATUS:   rd_mux_d = {5'h00, page_q, pcl_q, skip_q, cy_q,
                                       x_q, y_q, b_q, a_q};
            `REG_ETP:      rd_mux_d = {21'h000000, dr_q, e_q};
            `REG_ROM_ADDR: rd_mux_d = {21'h000000, rom_addr_q};
            `REG_ROM_DATA: rd_mux_d = {23'h000000, rom[rom_addr_q]};
            `REG_RAM_ADDR: rd_mux_d = {26'h0000000, ram_addr_q};
            `REG_RAM_DATA: rd_mux_d = {28'h0000000, ram[ram_addr_q]};
            default:       rd_mux_d = 32'h00000000;
        endcase
    end

    // Bus slave and execution state
    always @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            O_HRDATA    <= 32'h00000000;
            O_HREADYOUT <= 1'b1;
            O_HRESP     <= 1'b0;
            bus_addr_q  <= 6'h00;
            rd_pend_q   <= 1'b0;
            wr_pend_q   <= 1'b0;
            rom_addr_q  <= 11'h000;
            ram_addr_q  <= 6'h00;
            run_q       <= 1'b0;
            a_q         <= 4'h0;
            b_q         <= 4'h0;
            x_q         <= 2'h0;
            y_q         <= 4'h0;
            cy_q        <= 1'b0;
            e_q         <= 8'h00;
            dr_q        <= 3'h0;
            lo_q        <= `RST_LO;
            urs_q       <= 1'b0;
            page_q      <= `RST_PAGE;
            pcl_q       <= `RST_PCL;
            sp_q        <= 2'h0;
            cyc_q       <= `CYC_FETCH;
            op_q        <= 9'h000;
            tab_q       <= 11'h000;
            skip_q      <= 1'b0;
            two_skip_q  <= 1'b0;
            prev_lxy_q  <= 1'b0;
            prev_la_q   <= 1'b0;
        end
        else if (I_CE)
        begin
            // Core: one word per cycle, table lookup holds three
            if (run_q)
            begin
                case (cyc_q)
                    `CYC_FETCH:
                    begin
                        prev_lxy_q <= is_lxy;
                        prev_la_q  <= is_la;
                        skip_q     <= 1'b0;
                        pcl_q      <= pcl_inc;
                        if (is_two)
                        begin
                            op_q       <= word;
                            two_skip_q <= run_skip;
                            cyc_q      <= `CYC_WORD2;
                        end
                        else if (!run_skip)
                        begin
                            casez (word)
                                `OP_B: pcl_q <= word[6:0];
                                `OP_DEY:
                                begin
                                    y_q    <= y_dec;
                                    skip_q <= (y_dec == 4'hf);
                                end
                                `OP_INY:
                                begin
                                    y_q    <= y_inc;
                                    skip_q <= (y_inc == 4'h0);
                                end
                                `OP_TAM:
                                begin
                                    a_q <= mem;
                                    x_q <= x_q ^ word[1:0];
                                end
                                `OP_XAM:
                                begin
                                    a_q <= mem;
                                    x_q <= x_q ^ word[1:0];
                                end
                                `OP_SWAP_ACC_MEMORY_UP:
                                begin
                                    a_q    <= mem;
                                    x_q    <= x_q ^ word[1:0];
                                    y_q    <= y_inc;
                                    skip_q <= (y_inc == 4'h0);
                                end
                                `OP_SWAP_ACC_MEMORY_DOWN:
                                begin
                                    a_q    <= mem;
                                    x_q    <= x_q ^ word[1:0];
                                    y_q    <= y_dec;
                                    skip_q <= (y_dec == 4'hf);
                                end
                                `OP_LXY:
                                begin
                                    x_q <= word[5:4];
                                    y_q <= word[3:0];
                                end
                                `OP_LA: a_q <= word[3:0];
                                `OP_ROM_TABLE_LOOKUP:
                                begin
                                    sp_q  <= sp_q + 2'h1;
                                    tab_q <= {word[3:0], dr_q, a_q};
                                    cyc_q <= `CYC_TAB1;
                                end
                                `OP_TABLE_HIGH_BIT_ENABLE_SET: urs_q <= 1'b1;
                                `OP_AM: a_q <= sum_am[3:0];
                                `OP_AMC:
                                begin
                                    a_q  <= sum_amc[3:0];
                                    cy_q <= sum_amc[4];
                                end
                                `OP_AI:
                                begin
                                    a_q    <= sum_ai[3:0];
                                    skip_q <= ~sum_ai[4];
                                end
                                `OP_SC: cy_q <= 1'b1;
                                `OP_RC: cy_q <= 1'b0;
                                `OP_SZC: skip_q <= ~cy_q;
                                `OP_CMA: a_q <= ~a_q;
                                `OP_RAR:
                                begin
                                    a_q  <= {cy_q, a_q[3:1]};
                                    cy_q <= a_q[0];
                                end
                                `OP_GATE_FUNCTION_EXECUTE: a_q <= gate_d;
                                `OP_SZB:
                                    skip_q <= ~mem[word[1:0]];
                                `OP_SKIP_EQUAL_MEMORY:
                                    skip_q <= (a_q == mem);
                                default: skip_q <= 1'b0;
                            endcase
                        end
                    end
                    `CYC_WORD2:
                    begin
                        pcl_q  <= pcl_inc;
                        skip_q <= 1'b0;
                        cyc_q  <= `CYC_FETCH;
                        if (!two_skip_q)
                        begin
                            casez (op_q)
                                `OP_BL:
                                begin
                                    page_q <= op_q[3:0];
                                    pcl_q  <= word[6:0];
                                end
                                `OP_BA: pcl_q <= idx_pcl;
                                `OP_BLA:
                                begin
                                    page_q <= word[3:0];
                                    pcl_q  <= idx_pcl;
                                end
                                `OP_SEA:
                                    skip_q <= (a_q == word[3:0]);
                                default: skip_q <= 1'b0;
                            endcase
                        end
                    end
                    `CYC_TAB1:
                    begin
                        b_q   <= tab_wd[7:4];
                        a_q   <= tab_wd[3:0];
                        cyc_q <= `CYC_TAB2;
                        if (urs_q)
                            cy_q <= tab_wd[8];
                    end
                    default:
                    begin
                        {page_q, pcl_q} <= stack[sp_dec];
                        sp_q  <= sp_dec;
                        cyc_q <= `CYC_FETCH;
                    end
                endcase
            end

            // Bus write data phase
            if (wr_pend_q)
            begin
                wr_pend_q <= 1'b0;
                case (bus_addr_q)
                    `REG_CTRL:
                    begin
                        run_q <= I_HWDATA[`CTRL_RUN];
                        lo_q  <= I_HWDATA[`CTRL_LO_HI:`CTRL_LO_LO];
                        if (!(exec && word == `OP_TABLE_HIGH_BIT_ENABLE_SET))
                            urs_q <= I_HWDATA[`CTRL_URS];
                    end
                    `REG_ETP:
                    begin
                        e_q  <= I_HWDATA[7:0];
                        dr_q <= I_HWDATA[10:8];
                    end
                    `REG_ROM_ADDR: rom_addr_q <= I_HWDATA[10:0];
                    `REG_ROM_DATA: rom_addr_q <= rom_addr_q + 11'h001;
                    `REG_RAM_ADDR: ram_addr_q <= I_HWDATA[5:0];
                    default:       wr_pend_q  <= 1'b0;
                endcase
            end

            // Read wait state then data
            if (rd_pend_q)
            begin
                O_HRDATA    <= rd_mux_d;
                O_HREADYOUT <= 1'b1;
                rd_pend_q   <= 1'b0;
            end

            // Address phase
            if (bus_take)
            begin
                bus_addr_q <= I_HADDR[7:2];
                if (I_HWRITE)
                    wr_pend_q <= 1'b1;
                else
                begin
                    rd_pend_q   <= 1'b1;
                    O_HREADYOUT <= 1'b0;
                end
            end
        end
    end

endmodule // nibble_cpu_execute_core

// >>> nibble_cpu_execute_core_bench.sv
module nibble_cpu_execute_core_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic        ce = 1'h1;
    logic        hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    wire  [31:0] hrdata;
    wire         hready;
    int          num_errors = 0;
    int          n_tests = 0;
    int          rom[2048];
    int          mem[64];
    int          ma, mb, mx, my, mc, me, mdr, mlo, murs, mpc, sk, plxy, pla;
    int          prg[$];
    int          base[24] = '{9'h017, 9'h013, 9'h064, 9'h060, 9'h068, 9'h06c,
        9'h0c0, 9'h0b0, 9'h091, 9'h082, 9'h00a, 9'h00b, 9'h0a0, 9'h007,
        9'h006, 9'h02f, 9'h01c, 9'h01d, 9'h041, 9'h05c, 9'h04c, 9'h020,
        9'h026, 9'h025};
    int          msk[24] = '{0, 0, 3, 3, 3, 3, 63, 15, 0, 0, 0, 0, 15, 0, 0,
        0, 0, 0, 0, 3, 3, 3, 0, 0};

    always #5 clk = ~clk;

    nibble_cpu_execute_core dut (
        .I_CLK      (clk),
        .I_RESET    (rst),
        .I_CE       (ce),
        .I_HSEL     (hsel),
        .I_HADDR    (haddr),
        .I_HTRANS   (htrans),
        .I_HWRITE   (hwrite),
        .I_HSIZE    (3'h2),
        .I_HWDATA   (hwdata),
        .I_HREADY   (hready),
        .O_HRDATA   (hrdata),
        .O_HREADYOUT(hready),
        .O_HRESP    ()
    );

    task automatic test_done;
        if (num_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Waits for ready as sampled at a falling edge, bounded
    task automatic wait_rdy(output logic [31:0] d);
        logic r;
        int   n;
        n = 0;
        do
        begin
            @(negedge clk);
            r = hready;
            d = hrdata;
            @(posedge clk);
            n++;
        end while (!r && n < 20);
        if (!r)
        begin
            num_errors++;
            test_done;
        end
    endtask

    // One single word transfer: address phase, then data phase
    task automatic bus(input logic wr, input int i, input int wd,
                       output logic [31:0] d);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= 32'(i * 4);
        wait_rdy(d);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= 32'(wd);
        wait_rdy(d);
    endtask

    task automatic wr(input int i, input int v);
        logic [31:0] d;
        bus(1'h1, i, v, d);
    endtask

    task automatic rd(input int i, output logic [31:0] d);
        bus(1'h0, i, 0, d);
    endtask

    // Program memory load through the auto-incrementing data port
    task automatic load(input int a, input int q[$]);
        wr(3, a);
        foreach (q[i])
        begin
            wr(4, q[i]);
            rom[a + i] = q[i];
        end
    endtask

    // Reference model: executes one instruction word group
    task automatic step;
        logic [8:0] op;
        int         w2, nx, np, dp, m, t, q, lx, la, s;
        op = rom[mpc];
        nx = (mpc & 11'h780) | ((mpc + 1) & 7'h7f);
        w2 = rom[nx];
        np = nx;
        if (op == 9'h025 || op[8:4] == 5'h03 || op == 9'h001 || op == 9'h010)
            np = (nx & 11'h780) | ((nx + 1) & 7'h7f);
        dp = mx * 16 + my;
        m  = mem[dp];
        t  = (op == 9'h013 || op[8:2] == 7'h1a) ? 1 :
             (op == 9'h017 || op[8:2] == 7'h1b) ? 15 : 0;
        lx = op[8:6] == 3'h3;
        la = op[8:4] == 5'h0b;
        s  = 0;
        if (!(sk || (lx && plxy) || (la && pla)))
        begin
            if (op[8:4] == 5'h06)
                mx = mx ^ op[1:0];
            if (t > 0)
            begin
                my = (my + t) % 16;
                s  = my == (t == 1 ? 0 : 15);
            end
            casez (op)
                9'b1_1???_????: np = (mpc & 11'h780) | op[6:0];
                9'b0_0110_01??: ma = m;
                9'b0_0110_????:
                begin
                    mem[dp] = ma;
                    ma      = m;
                end
                9'b0_11??_????:
                begin
                    mx = op[5:4];
                    my = op[3:0];
                end
                9'b0_1011_????: ma = op[3:0];
                9'b0_1001_????:
                begin
                    q  = rom[op[3:0] * 128 + mdr * 16 + ma];
                    mb = q / 16 % 16;
                    ma = q % 16;
                    mc = murs ? q / 256 : mc;
                end
                9'h082: murs = 1;
                9'h00a: ma = (ma + m) % 16;
                9'h00b:
                begin
                    q  = ma + m + mc;
                    ma = q % 16;
                    mc = q / 16;
                end
                9'b0_1010_????:
                begin
                    q  = ma + op[3:0];
                    ma = q % 16;
                    s  = q < 16;
                end
                9'h006, 9'h007: mc = op[0];
                9'h02f: s = mc == 0;
                9'h01c: ma = 15 - ma;
                9'h01d:
                begin
                    q  = mc;
                    mc = ma % 2;
                    ma = ma / 2 + q * 8;
                end
                9'h041: ma = mlo == 0 ? ma ^ me % 16 :
                             mlo == 1 ? ma | me % 16 : ma & me % 16;
                9'b0_0101_11??: mem[dp] = m | 1 << op[1:0];
                9'b0_0100_11??: mem[dp] = m & ~(1 << op[1:0]) & 15;
                9'b0_0010_00??: s = !(m >> op[1:0] & 1);
                9'h026: s = ma == m;
                9'h025: s = ma == w2 % 16;
                9'b0_0011_????: np = op[3:0] * 128 + w2 % 128;
                9'h001: np = (mpc & 11'h780) | (w2 & 7'h70) | ma;
                9'h010: np = w2 % 16 * 128 + (w2 & 7'h70) + ma;
                default: ;
            endcase
        end
        sk   = s;
        plxy = lx;
        pla  = la;
        mpc  = np;
    endtask

    // Random program run against the model; parks in page 3 by value of A
    task automatic round(input int r);
        int          k;
        logic [31:0] d;
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        prg = {};
        while (prg.size() < 100)
        begin
            k = $urandom % 24;
            repeat ((k == 6 || k == 7) ? 1 + $urandom % 3 : 1)
                prg.push_back(base[k] | ($urandom & msk[k]));
            if (k == 23)
                prg.push_back(9'h0b0 | $urandom % 16);
        end
        load(0, prg);
        load(prg.size(), '{0, 0, 9'h032, 9'h185});
        load(261, '{9'h001, 9'h1f0});
        load(272, '{9'h010, 9'h1c3});
        for (int i = 0; i < 16; i++)
        begin
            load(368 + i, '{9'h190});
            load(448 + i, '{9'h180 | (64 + i)});
        end
        prg = {};
        repeat (128) prg.push_back($urandom % 512);
        load(128, prg);
        for (int i = 0; i < 64; i++)
        begin
            mem[i] = $urandom % 16;
            wr(5, i);
            wr(6, mem[i]);
        end
        me  = $urandom % 256;
        mdr = $urandom % 8;
        wr(2, mdr * 256 + me);
        wr(15, -1);
        rd(15, d);
        check(d, 0);
        mlo  = r % 4;
        murs = r / 4;
        wr(0, 1 + murs * 2 + mlo * 4);
        rd(0, d);
        check(d & 32'hd, 1 + mlo * 4);
        {ma, mb, mx, my, mc, mpc, sk, plxy, pla} = '0;
        repeat (1000)
            if (mpc / 16 != 28) step;
        // Random clock-enable gaps while the core runs; the bus stays idle
        repeat (1200)
        begin
            @(posedge clk);
            ce <= 1'($urandom % 2);
        end
        @(posedge clk);
        ce <= 1'h1;
        @(posedge clk);
        wr(0, 0);
        rd(1, d);
        check(d[3:0], ma);
        check(d[7:4], mb);
        check(d[11:8], my);
        check(d[13:12], mx);
        check(d[14], mc);
        check(d[26:16], mpc);
        check(d[15], 0);
        for (int i = 0; i < 64; i++)
        begin
            wr(5, i);
            rd(6, d);
            check(d, mem[i]);
        end
    endtask

    // Main sequence
    initial
    begin
        int s;
        s = $urandom(32'h7f1cce11);
        @(posedge clk);
        for (int r = 0; r < 8; r++)
            round(r);
        test_done;
    end
endmodule // nibble_cpu_execute_core_bench

// >>> nibble_cpu_execute_core_checker.sv
module nibble_cpu_execute_core_checker #(
    parameter STACK_DEPTH = 4
) (
    input wire        I_CLK,
    input wire        I_RESET,
    input wire        I_CE,
    input wire        I_HSEL,
    input wire [31:0] I_HADDR,
    input wire [1:0]  I_HTRANS,
    input wire        I_HWRITE,
    input wire [31:0] I_HWDATA,
    input wire        I_HREADY,
    input wire [31:0] O_HRDATA,
    input wire        O_HREADYOUT,
    input wire        O_HRESP
);
    timeunit 1ns;
    timeprecision 1ps;

    // Transfers accepted by the slave
    wire        take    = I_HSEL && I_HREADY && I_HTRANS[1] && I_CE;
    wire        rd_take = take && !I_HWRITE;
    logic       ctrl_wr_q;
    logic [3:0] ctrl_q;

    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    // Shadow of the last control word written by software
    always @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            ctrl_wr_q <= 1'h0;
            ctrl_q    <= 4'h0;
        end
        else
        begin
            ctrl_wr_q <= take && I_HWRITE && I_HADDR[7:2] == 6'h00;
            if (ctrl_wr_q)
                ctrl_q <= I_HWDATA[3:0];
        end
    end

    a_resp_okay: assert property (!O_HRESP)
        else $error("response not okay");
    a_read_wait: assert property (rd_take |=> !O_HREADYOUT ##1 O_HREADYOUT)
        else $error("read wait state wrong");
    a_write_nowait: assert property (take && I_HWRITE |=> O_HREADYOUT)
        else $error("write stalled");
    a_wait_cause: assert property ($fell(O_HREADYOUT) |-> $past(rd_take))
        else $error("wait state without read");
    a_wait_single: assert property (!O_HREADYOUT && I_CE |=> O_HREADYOUT)
        else $error("wait state too long");
    a_data_hold: assert property (!$rose(O_HREADYOUT) |-> $stable(O_HRDATA))
        else $error("read data changed");
    a_unmapped_zero: assert property (rd_take && I_HADDR[7:2] > 6'h06
        |=> ##1 O_HRDATA == 32'h0)
        else $error("unmapped read not zero");
    a_ctrl_readback: assert property (rd_take && I_HADDR[7:2] == 6'h00
        |=> ##1 O_HRDATA[31:4] == 28'h0 && O_HRDATA[0] == ctrl_q[0]
        && O_HRDATA[3:2] == ctrl_q[3:2])
        else $error("control readback wrong");
endmodule // nibble_cpu_execute_core_checker

bind nibble_cpu_execute_core nibble_cpu_execute_core_checker #(
    .STACK_DEPTH(STACK_DEPTH)
) u_checker (
    .I_CLK      (I_CLK),
    .I_RESET    (I_RESET),
    .I_CE       (I_CE),
    .I_HSEL     (I_HSEL),
    .I_HADDR    (I_HADDR),
    .I_HTRANS   (I_HTRANS),
    .I_HWRITE   (I_HWRITE),
    .I_HWDATA   (I_HWDATA),
    .I_HREADY   (I_HREADY),
    .O_HRDATA   (O_HRDATA),
    .O_HREADYOUT(O_HREADYOUT),
    .O_HRESP    (O_HRESP)
);
